// ---- sim/device_to_host_status_fis_tb.sv ----
// testbench joining device end and host end over the link
`timescale 1ns/1ps
module device_to_host_status_fis_tb;
    logic clk = 0, rstn = 0, ce = 1, bset = 0, iclr = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, x = 32'h5299;
    wire awready, wready, bvalid, arready, rvalid, irq, ipend, fok, fdrop, fbad;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] sst, serr, sdev;
    wire [23:0] slba, slbax;
    wire [15:0] ssect;
    int error_cnt = 0, comparisons = 0;
    dhf_link_if u_dhf_link_if();
    dhf_dev_end u_dhf_dev_end (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .IRQ_O(irq), .link(u_dhf_link_if));
    dhf_host_end u_dhf_host_end (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce),
        .link(u_dhf_link_if), .BSY_SET_I(bset), .INT_CLR_I(iclr),
        .SH_STATUS_O(sst), .SH_ERROR_O(serr), .SH_LBA_O(slba),
        .SH_DEVICE_O(sdev), .SH_LBAX_O(slbax), .SH_SECT_O(ssect),
        .INT_PEND_O(ipend), .FRAME_OK_O(fok), .FRAME_DROP_O(fdrop),
        .FRAME_BAD_O(fbad));
    dhf_link_sva u_dhf_link_sva (.CLK_I(clk), .RSTN_I(rstn),
        .fis_valid(u_dhf_link_if.fis_valid),
        .fis_ready(u_dhf_link_if.fis_ready),
        .fis_last(u_dhf_link_if.fis_last),
        .fis_data(u_dhf_link_if.fis_data));
    always #25 clk = ~clk;
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    // host shadow after a set-bits frame: busy and drq kept
    function automatic logic [7:0] sdb_exp(logic [7:0] o, logic [7:0] n,
                                           logic s);
        return {o[7], n[6:5], s, o[3], n[2:0]};
    endfunction
    // random stalls freeze both ends, so the link sees held words
    always @(posedge clk) ce <= (rnd() % 6) != 0;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ce at the falling edge is what the next rising edge samples
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            if (tb) chk(bresp, er);
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] er);
        logic ta, tr;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            if (tr) chk(rresp, er);
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end
    endtask
    task automatic pulse(input logic b);
        bset <= b;
        iclr <= !b;
        do @(negedge clk); while (!ce);
        @(posedge clk);
        bset <= 1'b0;
        iclr <= 1'b0;
    endtask
    task automatic send(input logic [1:0] k, input logic i, input logic s,
                        input logic [15:0] se);
        wr(8'h04, {16'h0, se}, 2'h0);
        wr(8'h00, {28'h0, s, i, k}, 2'h0);
    endtask
    task automatic frame(input logic ok);
        logic hit;
        hit = 1'b0;
        while (!hit) begin
            @(negedge clk);
            hit = fok || fdrop || fbad;
        end
        chk({fok, fdrop, fbad}, ok ? 3'h4 : 3'h2);
        @(posedge clk);
    endtask
    initial begin
        logic [31:0] d, lba, lbx;
        logic [15:0] se, sc;
        logic [7:0] ex;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk(sst, 8'h80);
        wr(8'h18, 32'h7, 2'h0);
        wr(8'h40, 32'h1, 2'h2);
        rd(8'h40, d, 2'h2);
        chk(d, 0);
        for (int n = 0; n < 4; n++) begin
            lba = rnd();
            lbx = rnd() & 32'hffffff;
            d = rnd();
            sc = d[31:16];
            se = d[15:0] & 16'hff67;
            wr(8'h08, lba, 2'h0);
            wr(8'h0c, lbx, 2'h0);
            wr(8'h10, {16'h0, sc}, 2'h0);
            pulse(1'b0);
            send(2'h1, d[0], 1'b0, se);
            frame(1'b1);
            chk({ssect, serr, sst}, {sc, se});
            chk({sdev, slba}, lba);
            chk(slbax, lbx);
            chk(ipend, d[0]);
            send(2'h1, 1'b0, 1'b0, ~se & 16'hff67);
            frame(1'b0);
            chk({serr, sst}, se);
            chk(irq, 1'b1);
            send(2'h1, 1'b0, 1'b1, se);
            rd(8'h14, d, 2'h0);
            chk(d, n ? 32'h7 : 32'h5);
            chk(irq, 1'b0);
            pulse(1'b0);
            d = rnd() | 32'h88;
            send(2'h2, 1'b0, 1'b1, d[15:0]);
            frame(1'b1);
            ex = sdb_exp(se[7:0], d[7:0], 1'b1);
            chk({serr, sst}, {d[15:8], ex});
            chk(ipend, 1'b1);
            pulse(1'b1);
            wr(8'h00, 32'h10, 2'h0);
            pulse(1'b0);
            d = rnd();
            send(2'h2, 1'b1, 1'b0, d[15:0]);
            frame(1'b1);
            chk(sst, sdb_exp(ex | 8'h80, d[7:0], 1'b0));
            chk(ipend, 1'b0);
            d = rnd() | 32'h80;
            send(2'h1, 1'b0, 1'b1, d[15:0]);
            frame(1'b1);
            chk(sst, d[7:0] | 8'h10);
            chk(ipend, 1'b0);
            $display("round %0d done", n);
        end
        conclude();
    end
    initial begin
        #1000000;
        error_cnt++;
        conclude();
    end
endmodule

// ---- sim/dhf_link_sva.sv ----
// checker for the frame words crossing the device-to-host link
`timescale 1ns/1ps
module dhf_link_sva (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic fis_valid,
    input wire logic fis_ready,
    input wire logic fis_last,
    input wire logic [31:0] fis_data
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    logic [2:0] wc_r;
    logic [7:0] ty_r;
    wire tk = fis_valid && fis_ready;
    // type is live on word zero, latched for the rest of the frame
    wire [7:0] ty = (wc_r == 3'h0) ? fis_data[7:0] : ty_r;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wc_r <= 3'h0;
            ty_r <= 8'h00;
        end else if (tk) begin
            wc_r <= fis_last ? 3'h0 : wc_r + 3'h1;
            ty_r <= ty;
        end
    end
    sequence s_stall;
        fis_valid && !fis_ready;
    endsequence
    sequence s_held;
        fis_valid && $stable(fis_data) && $stable(fis_last);
    endsequence
    property p_hold;
        s_stall |=> s_held;
    endproperty
    property p_type;
        fis_valid && wc_r == 3'h0 |-> fis_data[7:0] inside {8'h34, 8'ha1};
    endproperty
    property p_reg_len;
        fis_valid && ty == 8'h34 |-> fis_last == (wc_r == 3'h4);
    endproperty
    property p_sdb_len;
        fis_valid && ty == 8'ha1 |-> fis_last == (wc_r == 3'h1);
    endproperty
    property p_rsv0;
        fis_valid && wc_r == 3'h0 |-> !fis_data[15] && fis_data[13:8] == 6'h0;
    endproperty
    property p_sdb_rsv;
        fis_valid && ty == 8'ha1 |->
            (wc_r == 3'h0) ? !fis_data[19] && !fis_data[23] : fis_data == 0;
    endproperty
    property p_reg_tail;
        fis_valid && ty == 8'h34 && wc_r >= 3'h2 |-> fis_data[31:24] == 8'h0
            && (wc_r < 3'h3 || fis_data[23:16] == 8'h0)
            && (wc_r < 3'h4 || fis_data == 0);
    endproperty
    property p_alert;
        fis_valid && wc_r == 3'h0 && fis_data[7:0] == 8'ha1 && fis_data[20]
            |-> fis_data[14];
    endproperty
    a_hold: assert property (p_hold) else $error("stalled word changed");
    a_type: assert property (p_type) else $error("bad type code");
    a_reg_len: assert property (p_reg_len) else $error("reg len");
    a_sdb_len: assert property (p_sdb_len) else $error("sdb len");
    a_rsv0: assert property (p_rsv0) else $error("word0 rsv");
    a_sdb_rsv: assert property (p_sdb_rsv) else $error("sdb rsv");
    a_reg_tail: assert property (p_reg_tail) else $error("tail");
    a_alert: assert property (p_alert) else $error("no alert");
endmodule

// ---- src/dhf_dev_end.sv ----
// device end: builds register and set-bits frames from axi-lite registers
`timescale 1ns/1ps
// Summary of operation
// - frame type code sits in byte zero
// - register frame is type 34h, five words
// - status field carries value for shadow status
// - register frame alert flag follows own interrupt-pending state only
// - register frame sets service only while busy/drq
// - carried service flag mirrors pending service requests
// - host copies all register fields into shadows
// - host drops register frame when busy, drq clear
// - set-bits frame is type A1h, two words
// - host loads error and status groups 6:4, 2:0
// - set-bits frame never touches busy or drq
// - alert with busy, drq clear raises pending
// - service via set-bits frame also sets alert
module dhf_dev_end (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic CE_I,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic IRQ_O,
    dhf_link_if.dev link
);
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == dhf_pkg::OFF_CTRL || a == dhf_pkg::OFF_STERR ||
               a == dhf_pkg::OFF_LBA || a == dhf_pkg::OFF_LBAX ||
               a == dhf_pkg::OFF_SECT || a == dhf_pkg::OFF_EVT ||
               a == dhf_pkg::OFF_MASK;
    endfunction

    logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r, rdata_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;
    logic irq_pend_r, serv_pend_r, sh_bsy_r, sh_drq_r;
    logic [15:0] sterr_r, sect_r;
    logic [31:0] lba_r;
    logic [23:0] lbax_r;
    logic [dhf_pkg::EV_W-1:0] evt_r, mask_r, evt_set, evt_clr;
    dhf_pkg::dhf_tx_t state_r;
    logic [31:0] frame_r [0:dhf_pkg::MAX_WORDS-1];
    logic [31:0] img [0:dhf_pkg::MAX_WORDS-1];
    logic [2:0] idx_r, len_r;
    logic kind_sdb_r, valid_r, last_r;
    logic [31:0] data_r;
    logic wr_fire, rd_fire, ctrl_wr, req_reg, req_sdb, req_any;
    logic start, refuse, word_go, irq_new, serv_new;
    logic [31:0] ctrl_word;
    logic [7:0] st_tx;

    // bus handshakes; ready and valid held low while the enable is low
    assign S_AXI_AWREADY_O = CE_I && !aw_got_r;
    assign S_AXI_WREADY_O = CE_I && !w_got_r;
    assign S_AXI_ARREADY_O = CE_I && !rvalid_r;
    assign S_AXI_BVALID_O = bvalid_r && CE_I;
    assign S_AXI_BRESP_O = bresp_r;
    assign S_AXI_RVALID_O = rvalid_r && CE_I;
    assign S_AXI_RDATA_O = rdata_r;
    assign S_AXI_RRESP_O = rresp_r;
    assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
    assign rd_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= dhf_pkg::RESP_OKAY;
        end else if (CE_I) begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_got_r <= 1'b1;
                w_data_r <= S_AXI_WDATA_I;
                w_strb_r <= S_AXI_WSTRB_I;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= mapped(aw_addr_r) ? dhf_pkg::RESP_OKAY
                                             : dhf_pkg::RESP_SLVERR;
            end else if (bvalid_r && S_AXI_BREADY_I) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // send requests are pulses written into the control word, lane 0
    assign ctrl_wr = wr_fire && aw_addr_r == dhf_pkg::OFF_CTRL && w_strb_r[0];
    assign req_reg = ctrl_wr && w_data_r[dhf_pkg::CT_SEND_REG];
    assign req_sdb = ctrl_wr && w_data_r[dhf_pkg::CT_SEND_SDB] && !req_reg;
    assign req_any = req_reg || req_sdb;
    assign irq_new = w_data_r[dhf_pkg::CT_IRQ_PEND];
    assign serv_new = w_data_r[dhf_pkg::CT_SERV_PEND];
    // a register frame carrying service needs busy or drq at the host
    assign refuse = req_any && (state_r != dhf_pkg::TX_IDLE || (req_reg &&
                    serv_new && !sh_bsy_r && !sh_drq_r));
    assign start = req_any && !refuse;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            irq_pend_r <= 1'b0;
            serv_pend_r <= 1'b0;
            sterr_r <= 16'h0000;
            lba_r <= 32'h0000_0000;
            lbax_r <= 24'h00_0000;
            sect_r <= 16'h0000;
            mask_r <= '0;
        end else if (CE_I && wr_fire) begin
            unique case (aw_addr_r)
                dhf_pkg::OFF_CTRL: begin
                    if (w_strb_r[0]) begin
                        irq_pend_r <= w_data_r[dhf_pkg::CT_IRQ_PEND];
                        serv_pend_r <= w_data_r[dhf_pkg::CT_SERV_PEND];
                    end
                end
                dhf_pkg::OFF_STERR: begin
                    sterr_r <= 16'(merge({16'h0000, sterr_r}, w_data_r,
                                         w_strb_r));
                end
                dhf_pkg::OFF_LBA: lba_r <= merge(lba_r, w_data_r, w_strb_r);
                dhf_pkg::OFF_LBAX: begin
                    lbax_r <= 24'(merge({8'h00, lbax_r}, w_data_r,
                                        w_strb_r));
                end
                dhf_pkg::OFF_SECT: begin
                    sect_r <= 16'(merge({16'h0000, sect_r}, w_data_r,
                                        w_strb_r));
                end
                dhf_pkg::OFF_MASK: begin
                    if (w_strb_r[0]) begin
                        mask_r <= w_data_r[dhf_pkg::EV_W-1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // device's view of the host's shadow busy and drq
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sh_bsy_r <= dhf_pkg::SHADOW_ST_RST[dhf_pkg::ST_BSY];
            sh_drq_r <= dhf_pkg::SHADOW_ST_RST[dhf_pkg::ST_DRQ];
        end else if (CE_I) begin
            if (word_go && last_r && !kind_sdb_r) begin
                sh_bsy_r <= frame_r[0][dhf_pkg::STAT_POS + dhf_pkg::ST_BSY];
                sh_drq_r <= frame_r[0][dhf_pkg::STAT_POS + dhf_pkg::ST_DRQ];
            end else if (ctrl_wr && w_data_r[dhf_pkg::CT_CMD_SEEN]) begin
                sh_bsy_r <= 1'b1;
            end
        end
    end

    // flags follow the write asking for the frame, never stale bits
    always_comb begin
        st_tx = sterr_r[7:0];
        st_tx[dhf_pkg::ST_SERV] = serv_new;
    end

    // frame image; every position not written stays zero
    always_comb begin
        for (int i = 0; i < dhf_pkg::MAX_WORDS; i++) begin
            img[i] = 32'h0000_0000;
        end
        if (req_sdb) begin
            img[0][dhf_pkg::TYPE_POS +: 8] = dhf_pkg::FIS_SDB;
            img[0][dhf_pkg::SDB_LO_POS +: 3] = st_tx[2:0];
            img[0][dhf_pkg::SDB_HI_POS +: 3] = st_tx[6:4];
            // service through this frame always carries the alert
            img[0][dhf_pkg::IRQ_POS] = irq_new || serv_new;
            img[0][dhf_pkg::ERR_POS +: 8] = sterr_r[15:8];
        end else begin
            img[0][dhf_pkg::TYPE_POS +: 8] = dhf_pkg::FIS_REG_D2H;
            // no host irq-disable input: alert is never gated by it
            img[0][dhf_pkg::IRQ_POS] = irq_new;
            img[0][dhf_pkg::STAT_POS +: 8] = st_tx;
            img[0][dhf_pkg::ERR_POS +: 8] = sterr_r[15:8];
            img[1] = lba_r;
            img[2][23:0] = lbax_r;
            img[3][15:0] = sect_r;
        end
    end

    assign word_go = valid_r && link.fis_ready;

    // transmit sequencer; type code always leads in word 0
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_r <= dhf_pkg::TX_IDLE;
            for (int i = 0; i < dhf_pkg::MAX_WORDS; i++) begin
                frame_r[i] <= 32'h0000_0000;
            end
            idx_r <= 3'h0;
            len_r <= 3'h0;
            kind_sdb_r <= 1'b0;
            valid_r <= 1'b0;
            last_r <= 1'b0;
            data_r <= 32'h0000_0000;
        end else if (CE_I) begin
            unique case (state_r)
                dhf_pkg::TX_IDLE: begin
                    if (start) begin
                        frame_r <= img;
                        kind_sdb_r <= req_sdb;
                        len_r <= req_sdb ? dhf_pkg::SDB_LEN
                                         : dhf_pkg::REG_LEN;
                        idx_r <= 3'h0;
                        data_r <= img[0];
                        valid_r <= 1'b1;
                        last_r <= 1'b0;
                        state_r <= dhf_pkg::TX_SEND;
                    end
                end
                dhf_pkg::TX_SEND: begin
                    if (word_go) begin
                        if (last_r) begin
                            valid_r <= 1'b0;
                            last_r <= 1'b0;
                            state_r <= dhf_pkg::TX_IDLE;
                        end else begin
                            idx_r <= idx_r + 3'h1;
                            data_r <= frame_r[idx_r + 3'h1];
                            last_r <= (idx_r + 3'h2) == len_r;
                        end
                    end
                end
            endcase
        end
    end

    assign link.fis_valid = valid_r;
    assign link.fis_last = last_r;
    assign link.fis_data = data_r;

    // sticky events; a read clears, a new event in that cycle survives
    always_comb begin
        evt_set = '0;
        evt_set[dhf_pkg::EV_REG_DONE] = word_go && last_r && !kind_sdb_r;
        evt_set[dhf_pkg::EV_SDB_DONE] = word_go && last_r && kind_sdb_r;
        evt_set[dhf_pkg::EV_REFUSED] = refuse;
        evt_clr = (rd_fire && S_AXI_ARADDR_I == dhf_pkg::OFF_EVT) ?
                  '1 : '0;
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            evt_r <= '0;
        end else if (CE_I) begin
            evt_r <= (evt_r & ~evt_clr) | evt_set;
        end
    end

    assign IRQ_O = |(evt_r & mask_r);

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[dhf_pkg::CT_IRQ_PEND] = irq_pend_r;
        ctrl_word[dhf_pkg::CT_SERV_PEND] = serv_pend_r;
        ctrl_word[dhf_pkg::CT_SH_DRQ] = sh_drq_r;
        ctrl_word[dhf_pkg::CT_SH_BSY] = sh_bsy_r;
        ctrl_word[dhf_pkg::CT_TX_BUSY] = state_r != dhf_pkg::TX_IDLE;
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= dhf_pkg::RESP_OKAY;
        end else if (CE_I) begin
            if (rd_fire) begin
                rvalid_r <= 1'b1;
                rresp_r <= mapped(S_AXI_ARADDR_I) ? dhf_pkg::RESP_OKAY
                                                  : dhf_pkg::RESP_SLVERR;
                unique case (S_AXI_ARADDR_I)
                    dhf_pkg::OFF_CTRL: rdata_r <= ctrl_word;
                    dhf_pkg::OFF_STERR: rdata_r <= {16'h0000, sterr_r};
                    dhf_pkg::OFF_LBA: rdata_r <= lba_r;
                    dhf_pkg::OFF_LBAX: rdata_r <= {8'h00, lbax_r};
                    dhf_pkg::OFF_SECT: rdata_r <= {16'h0000, sect_r};
                    dhf_pkg::OFF_EVT: rdata_r <= {29'h0, evt_r};
                    dhf_pkg::OFF_MASK: rdata_r <= {29'h0, mask_r};
                    default: rdata_r <= 32'h0000_0000;
                endcase
            end else if (rvalid_r && S_AXI_RREADY_I) begin
                rvalid_r <= 1'b0;
            end
        end
    end
endmodule

// ---- src/dhf_host_end.sv ----
// host end: decodes received frames into shadow registers
`timescale 1ns/1ps
module dhf_host_end (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic CE_I,
    dhf_link_if.hst link,
    input wire logic BSY_SET_I,
    input wire logic INT_CLR_I,
    output logic [7:0] SH_STATUS_O,
    output logic [7:0] SH_ERROR_O,
    output logic [23:0] SH_LBA_O,
    output logic [7:0] SH_DEVICE_O,
    output logic [23:0] SH_LBAX_O,
    output logic [15:0] SH_SECT_O,
    output logic INT_PEND_O,
    output logic FRAME_OK_O,
    output logic FRAME_DROP_O,
    output logic FRAME_BAD_O
);
    logic [31:0] buf_r [0:dhf_pkg::MAX_WORDS-1];
    logic [2:0] cnt_r, len_r;
    logic done_r, ok_r, drop_r, bad_r, int_r;
    logic [7:0] st_r, err_r, dev_r, st_nxt;
    logic [23:0] lba_r, lbax_r;
    logic [15:0] sect_r;
    logic take, is_reg, is_sdb, bd_clear, int_set;
    logic [7:0] typ;

    // no buffering beyond the frame store: accept whenever enabled
    assign link.fis_ready = CE_I;
    assign take = link.fis_valid && CE_I;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < dhf_pkg::MAX_WORDS; i++) begin
                buf_r[i] <= 32'h0000_0000;
            end
            cnt_r <= 3'h0;
            len_r <= 3'h0;
            done_r <= 1'b0;
        end else if (CE_I) begin
            done_r <= take && link.fis_last;
            if (take) begin
                // words past the longest frame only count toward length
                if (cnt_r < dhf_pkg::REG_LEN) begin
                    buf_r[cnt_r] <= link.fis_data;
                end
                if (link.fis_last) begin
                    len_r <= cnt_r + 3'h1;
                    cnt_r <= 3'h0;
                end else if (cnt_r != 3'h7) begin
                    cnt_r <= cnt_r + 3'h1;
                end
            end
        end
    end

    assign typ = buf_r[0][dhf_pkg::TYPE_POS +: 8];
    assign is_reg = done_r && typ == dhf_pkg::FIS_REG_D2H &&
                    len_r == dhf_pkg::REG_LEN;
    assign is_sdb = done_r && typ == dhf_pkg::FIS_SDB &&
                    len_r == dhf_pkg::SDB_LEN;
    assign bd_clear = !st_r[dhf_pkg::ST_BSY] && !st_r[dhf_pkg::ST_DRQ];

    always_comb begin
        st_nxt = st_r;
        if (is_reg && !bd_clear) begin
            st_nxt = buf_r[0][dhf_pkg::STAT_POS +: 8];
        end else if (is_sdb) begin
            // busy and drq bits are left as they stand
            st_nxt[6:4] = buf_r[0][dhf_pkg::SDB_HI_POS +: 3];
            st_nxt[2:0] = buf_r[0][dhf_pkg::SDB_LO_POS +: 3];
        end
        if (BSY_SET_I) begin
            st_nxt[dhf_pkg::ST_BSY] = 1'b1;
        end
    end

    // reserved positions are never looked at
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st_r <= dhf_pkg::SHADOW_ST_RST;
            err_r <= 8'h00;
            dev_r <= 8'h00;
            lba_r <= 24'h00_0000;
            lbax_r <= 24'h00_0000;
            sect_r <= 16'h0000;
        end else if (CE_I) begin
            st_r <= st_nxt;
            if (is_reg && !bd_clear) begin
                err_r <= buf_r[0][dhf_pkg::ERR_POS +: 8];
                lba_r <= buf_r[1][23:0];
                dev_r <= buf_r[1][31:24];
                lbax_r <= buf_r[2][23:0];
                sect_r <= buf_r[3][15:0];
            end else if (is_sdb) begin
                err_r <= buf_r[0][dhf_pkg::ERR_POS +: 8];
            end
        end
    end

    assign int_set = buf_r[0][dhf_pkg::IRQ_POS] &&
                     ((is_reg && !bd_clear) ||
                      (is_sdb && bd_clear));

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            int_r <= 1'b0;
            ok_r <= 1'b0;
            drop_r <= 1'b0;
            bad_r <= 1'b0;
        end else if (CE_I) begin
            // a new interrupt in the clearing cycle is kept
            int_r <= int_set || (int_r && !INT_CLR_I);
            ok_r <= (is_reg && !bd_clear) || is_sdb;
            drop_r <= is_reg && bd_clear;
            bad_r <= done_r && !is_reg && !is_sdb;
        end
    end

    assign SH_STATUS_O = st_r;
    assign SH_ERROR_O = err_r;
    assign SH_LBA_O = lba_r;
    assign SH_DEVICE_O = dev_r;
    assign SH_LBAX_O = lbax_r;
    assign SH_SECT_O = sect_r;
    assign INT_PEND_O = int_r;
    assign FRAME_OK_O = ok_r;
    assign FRAME_DROP_O = drop_r;
    assign FRAME_BAD_O = bad_r;
endmodule

// ---- src/dhf_link_if.sv ----
// word link carrying frames from device end to host end
`timescale 1ns/1ps
interface dhf_link_if;
    logic fis_valid;
    logic fis_ready;
    logic fis_last;
    logic [31:0] fis_data;
    modport dev (output fis_valid, output fis_last, output fis_data,
                 input fis_ready);
    modport hst (input fis_valid, input fis_last, input fis_data,
                 output fis_ready);
endinterface

// ---- src/dhf_pkg.sv ----
// shared constants for the device-to-host status frame ends
package dhf_pkg;
    // frame type codes and lengths in words
    localparam logic [7:0] FIS_REG_D2H = 8'h34;
    localparam logic [7:0] FIS_SDB = 8'ha1;
    localparam logic [2:0] REG_LEN = 3'h5;
    localparam logic [2:0] SDB_LEN = 3'h2;
    localparam int MAX_WORDS = 5;
    // field positions inside word 0
    localparam int TYPE_POS = 0;
    localparam int IRQ_POS = 14;
    localparam int STAT_POS = 16;
    localparam int ERR_POS = 24;
    localparam int SDB_LO_POS = 16;
    localparam int SDB_HI_POS = 20;
    // status byte bit positions
    localparam int ST_BSY = 7;
    localparam int ST_DRQ = 3;
    localparam int ST_SERV = 4;
    // host shadow status after reset: busy
    localparam logic [7:0] SHADOW_ST_RST = 8'h80;
    // device register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STERR = 8'h04;
    localparam logic [7:0] OFF_LBA = 8'h08;
    localparam logic [7:0] OFF_LBAX = 8'h0c;
    localparam logic [7:0] OFF_SECT = 8'h10;
    localparam logic [7:0] OFF_EVT = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    // control register bits
    localparam int CT_SEND_REG = 0;
    localparam int CT_SEND_SDB = 1;
    localparam int CT_IRQ_PEND = 2;
    localparam int CT_SERV_PEND = 3;
    localparam int CT_CMD_SEEN = 4;
    localparam int CT_SH_DRQ = 8;
    localparam int CT_SH_BSY = 9;
    localparam int CT_TX_BUSY = 16;
    // event bits
    localparam int EV_REG_DONE = 0;
    localparam int EV_SDB_DONE = 1;
    localparam int EV_REFUSED = 2;
    localparam int EV_W = 3;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} dhf_tx_t;
endpackage
